// ==== inc/hpcr_pkg.sv ====
// package of the hub port configuration register slice
// assumes a byte-wide register port and active-high asynchronous reset
package hpcr_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CHARGE   = 8'h06;
  localparam logic [7:0] ADDR_REMOVE   = 8'h07;
  localparam logic [7:0] ADDR_PORTUSE  = 8'h08;
  localparam logic [7:0] ADDR_PHY      = 8'h09;
  localparam logic [7:0] ADDR_SET2     = 8'h0A;

  // ****************************************************************
  // reset values and field layout
  // ****************************************************************
  localparam logic [7:0] RESET_ZERO    = 8'h00;
  localparam logic [7:0] PORTUSE_VALUE = 8'h00;
  localparam logic [7:0] PHY_RESET     = 8'h00;
  localparam logic [7:0] PHY_WR_MASK   = 8'h23;
  localparam logic [7:0] SET2_RESET    = 8'h00;
  localparam logic [7:0] SET2_WR_MASK  = 8'h7E;
  localparam logic [7:0] SET2_OTP_MASK = 8'h12;
  localparam int         OVR_BIT       = 7;
  localparam int         RMV_RSVD_HI   = 3;
  localparam int         RMV_RSVD_LO   = 2;
  localparam int         CUSTOM_BIT    = 6;
  localparam int         POL_BIT       = 5;
  localparam int         HICUR_BIT     = 4;
  localparam int         AUTO_BIT      = 1;

  // ****************************************************************
  // reset-release capture sequence
  // ****************************************************************
  typedef enum logic [1:0]
  {
    CAP_WAIT = 2'b00,
    CAP_LOAD = 2'b01,
    CAP_DONE = 2'b11
  } hpcr_cap_t;

endpackage

// ==== inc/hpcr_strap_if.sv ====
// interface carrying terminal levels caught at reset release
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface hpcr_strap_if #(parameter int NUM_PORTS = 2);
  logic                 load;
  logic [NUM_PORTS-1:0] chg;
  logic                 pol;
  modport src (output load, output chg, output pol);
  modport dst (input load, input chg, input pol);
endinterface

// ==== rtl/hpcr_regs.sv ====
// byte-wide port configuration registers at offsets 6h to Ah
// assumes the serial loader or bus slave presents one access per cycle
`timescale 1ns/1ps
// What this block does
// - Offset 6h bits 1:0 enable charging features on ports 1 and 2.
// - Those enable bits take the charge terminal levels at reset release.
// - In configuration mode the loader or bus host may overwrite them.
// - Reserved bits 7:2 at 6h, 6:2 at 7h, 7:6 and 4:2 at 9h read zero.
// - With the override bit 7 of 7h set, its port bits give removability.
// - Port bit n stands for port n+1, one meaning removable.
// - With override clear the port bits are fixed to the inverted fuse field.
// - Bits 3:2 at 7h take writes but always read zero.
// - Bits 7 and 0 at Ah are read-only zero.
module hpcr_regs #(parameter int NUM_PORTS = 2)
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // terminals and fuses
  input  wire logic [NUM_PORTS-1:0] power_charge_pins,
  input  wire logic                 polarity_pin,
  input  wire logic [NUM_PORTS-1:0] fixed_attach,
  input  wire logic                 otp_high_current,
  input  wire logic                 otp_auto_mode_off,
  input  wire logic                 cfg_mode,
  // register port
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wr_data,
  output logic      [7:0]           rd_data,
  output logic                      rd_valid,
  // configuration outputs
  output logic      [NUM_PORTS-1:0] charge_port_enable,
  output logic      [NUM_PORTS-1:0] port_removable,
  output logic                      removable_override,
  output logic      [7:0]           phy_tuning,
  output logic      [7:0]           settings2
);

  typedef struct packed
  {
    logic [NUM_PORTS-1:0] chg;
    logic                 ovr;
    logic [1:0]           rmv_rsvd;
    logic [NUM_PORTS-1:0] rmv;
    logic [NUM_PORTS-1:0] rmv_eff;
    logic [7:0]           phy;
    logic [7:0]           s2;
    logic [7:0]           s2_eff;
    logic [7:0]           rd_data;
    logic                 rd_valid;
  } hpcr_regs_t;

  hpcr_regs_t s_reg;
  hpcr_regs_t s_next;

  hpcr_strap_if #(.NUM_PORTS(NUM_PORTS)) strap ();

  hpcr_strap_capture #(.NUM_PORTS(NUM_PORTS)) u_cap
  (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .power_charge_pins (power_charge_pins),
    .polarity_pin      (polarity_pin),
    .strap             (strap.src)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [7:0]           otp_vec;
  logic [7:0]           s2_mask;
  logic [7:0]           rd_val;
  logic [NUM_PORTS-1:0] rmv_view;

  always_comb
  begin
    otp_vec            = hpcr_pkg::RESET_ZERO;
    otp_vec[hpcr_pkg::HICUR_BIT] = otp_high_current;
    otp_vec[hpcr_pkg::AUTO_BIT]  = otp_auto_mode_off;
    s2_mask            = hpcr_pkg::SET2_WR_MASK;
    rmv_view           = s_reg.ovr ? s_reg.rmv : ~fixed_attach;
    rd_val             = hpcr_pkg::RESET_ZERO;
    s_next             = s_reg;
    s_next.rd_valid    = 1'b0;
    if (strap.load)
    begin
      s_next.chg = strap.chg;
      s_next.s2[hpcr_pkg::POL_BIT] = ~strap.pol;
    end
    else if (wr_en)
    begin
      if (addr == hpcr_pkg::ADDR_CHARGE)
      begin
        if (cfg_mode)
          s_next.chg = wr_data[NUM_PORTS-1:0];
      end
      else if (addr == hpcr_pkg::ADDR_REMOVE)
      begin
        s_next.ovr = wr_data[hpcr_pkg::OVR_BIT];
        s_next.rmv_rsvd =
          wr_data[hpcr_pkg::RMV_RSVD_HI:hpcr_pkg::RMV_RSVD_LO];
        if (s_reg.ovr)
          s_next.rmv = wr_data[NUM_PORTS-1:0];
      end
      else if (addr == hpcr_pkg::ADDR_PHY)
      begin
        s_next.phy = wr_data & hpcr_pkg::PHY_WR_MASK;
      end
      else if (addr == hpcr_pkg::ADDR_SET2)
      begin
        if (!wr_data[hpcr_pkg::CUSTOM_BIT])
          s2_mask = s2_mask & ~hpcr_pkg::SET2_OTP_MASK;
        s_next.s2 = (s_reg.s2 & ~s2_mask) | (wr_data & s2_mask);
      end
    end
    s_next.rmv_eff = rmv_view;
    if (s_reg.s2[hpcr_pkg::CUSTOM_BIT])
      s_next.s2_eff = s_reg.s2;
    else
      s_next.s2_eff = (s_reg.s2 & ~hpcr_pkg::SET2_OTP_MASK) | otp_vec;
    if (addr == hpcr_pkg::ADDR_CHARGE)
      rd_val = 8'(s_reg.chg);
    else if (addr == hpcr_pkg::ADDR_REMOVE)
    begin
      rd_val = 8'(rmv_view);
      rd_val[hpcr_pkg::OVR_BIT] = s_reg.ovr;
    end
    else if (addr == hpcr_pkg::ADDR_PORTUSE)
      rd_val = hpcr_pkg::PORTUSE_VALUE;
    else if (addr == hpcr_pkg::ADDR_PHY)
      rd_val = s_reg.phy & hpcr_pkg::PHY_WR_MASK;
    else if (addr == hpcr_pkg::ADDR_SET2)
      rd_val = s_next.s2_eff & hpcr_pkg::SET2_WR_MASK;
    if (rd_en)
    begin
      s_next.rd_valid = 1'b1;
      s_next.rd_data  = rd_val;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg     <= '0;
      s_reg.phy <= hpcr_pkg::PHY_RESET;
      s_reg.s2  <= hpcr_pkg::SET2_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign rd_data            = s_reg.rd_data;
  assign rd_valid           = s_reg.rd_valid;
  assign charge_port_enable = s_reg.chg;
  assign port_removable     = s_reg.rmv_eff;
  assign removable_override = s_reg.ovr;
  assign phy_tuning         = s_reg.phy;
  assign settings2          = s_reg.s2_eff;

  // ****************************************************************
  // checks
  // ****************************************************************
  chg_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en && cfg_mode && !strap.load && addr == hpcr_pkg::ADDR_CHARGE
    |=> charge_port_enable == $past(wr_data[NUM_PORTS-1:0]))
    else $error("charge enable write lost");

  chg_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg_mode && !strap.load |=> $stable(charge_port_enable))
    else $error("charge enable changed outside config mode");

  strap_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    strap.load |=> charge_port_enable == $past(strap.chg))
    else $error("charge default not taken from terminals");

  rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && addr == hpcr_pkg::ADDR_PHY
    |=> rd_valid && rd_data[7:6] == 2'h0 && rd_data[4:2] == 3'h0)
    else $error("reserved phy bits not zero");

  chg_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && addr == hpcr_pkg::ADDR_CHARGE
    |=> rd_data[7:2] == 6'h00 && rd_data[1:0] == $past(s_reg.chg))
    else $error("charge register read wrong");

  ovr_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && s_reg.ovr && addr == hpcr_pkg::ADDR_REMOVE
    |=> rd_data[1:0] == $past(s_reg.rmv))
    else $error("override removable bits not reported");

  port_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_reg.ovr && $stable(s_reg.rmv) |=> port_removable == $past(s_reg.rmv))
    else $error("removable output does not follow port bits");

  fuse_view_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && !s_reg.ovr && addr == hpcr_pkg::ADDR_REMOVE
    |=> rd_data[1:0] == ~$past(fixed_attach))
    else $error("removable bits not inverted fuse field");

  rmv_rsvd_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && addr == hpcr_pkg::ADDR_REMOVE |=> rd_data[6:2] == 5'h00)
    else $error("removable reserved bits not zero");

  set2_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_en && addr == hpcr_pkg::ADDR_SET2
    |=> rd_data[7] == 1'b0 && rd_data[0] == 1'b0)
    else $error("settings2 read-only bits not zero");

  ro_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en && !s_reg.ovr && addr == hpcr_pkg::ADDR_REMOVE
    |=> $stable(s_reg.rmv))
    else $error("read-only removable bits written");

endmodule

// ==== rtl/hpcr_strap_capture.sv ====
// catches terminal levels once, at the first edge after reset release
// assumes the terminal inputs are synchronous to sys_clk
`timescale 1ns/1ps
module hpcr_strap_capture #(parameter int NUM_PORTS = 2)
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // terminals
  input  wire logic [NUM_PORTS-1:0] power_charge_pins,
  input  wire logic                 polarity_pin,
  // captured values
  hpcr_strap_if.src                 strap
);

  typedef struct packed
  {
    hpcr_pkg::hpcr_cap_t  st;
    logic                 load;
    logic [NUM_PORTS-1:0] chg;
    logic                 pol;
  } hpcr_cap_state_t;

  hpcr_cap_state_t s_reg;
  hpcr_cap_state_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.load = 1'b0;
    case (s_reg.st)
      hpcr_pkg::CAP_WAIT:
      begin
        s_next.chg  = power_charge_pins;
        s_next.pol  = polarity_pin;
        s_next.load = 1'b1;
        s_next.st   = hpcr_pkg::CAP_LOAD;
      end
      hpcr_pkg::CAP_LOAD:
        s_next.st = hpcr_pkg::CAP_DONE;
      default:
        s_next.st = hpcr_pkg::CAP_DONE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign strap.load = s_reg.load;
  assign strap.chg  = s_reg.chg;
  assign strap.pol  = s_reg.pol;

  // ****************************************************************
  // checks
  // ****************************************************************
  cap_once_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_reg.load |=> (!s_reg.load) [*3])
    else $error("terminal capture repeated");

endmodule

// ==== tb/hpcr_host_model.sv ====
// host model issuing single-byte register reads and writes
// assumes one-cycle strobes sampled on the rising edge of sys_clk
`timescale 1ns/1ps
module hpcr_host_model
(
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial
  begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    addr    = 8'hFF;
    wr_data = 8'hFF;
  end

  // one write, idle lines show the inverse afterwards
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == 8'h09) ? (d & 8'hDC) : d;
    @(posedge sys_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= v;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
    addr    <= ~a;
    wr_data <= ~v;
  endtask

  // one read, answer taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic vld);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    #1;
    vld = rd_valid;
    d   = rd_data;
  endtask
endmodule

// ==== tb/hub_port_config_registers_bench.sv ====
// bench for the port configuration register slice
// assumes hpcr_regs with two ports and the host model beside it
`timescale 1ns/1ps
module hub_port_config_registers_bench;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] pins = 2'h2;
  logic       pol = 1'b0;
  logic [1:0] fixed_attach = 2'h1;
  logic       cfg_mode = 1'b0;
  logic       wr_en, rd_en, rd_valid, ovr;
  logic [7:0] addr, wr_data, rd_data, phy, set2;
  logic [1:0] chg, rmv;
  int         fails = 0;
  int         samples_checked = 0;

  always #2 sys_clk = ~sys_clk;

  hpcr_host_model host (.sys_clk(sys_clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  hpcr_regs #(.NUM_PORTS(2)) DUT (.sys_clk(sys_clk), .rst(rst),
    .power_charge_pins(pins), .polarity_pin(pol),
    .fixed_attach(fixed_attach), .otp_high_current(1'b1),
    .otp_auto_mode_off(1'b1), .cfg_mode(cfg_mode), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .charge_port_enable(chg), .port_removable(rmv),
    .removable_override(ovr), .phy_tuning(phy), .settings2(set2));

  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic rchk(string n, logic [7:0] a, logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    check({n, "_valid"}, {7'h0, v}, 8'h01);
    check(n, d, exp);
  endtask

  task automatic give_verdict;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // reset with given terminal levels, then defaults read back
  task automatic t_reset(logic [1:0] p, logic pl);
    @(posedge sys_clk);
    rst  <= 1'b1;
    pins <= p;
    pol  <= pl;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("chg_out", {6'h0, chg}, {6'h0, p});
    rchk("charge", 8'h06, {6'h0, p});
    rchk("set2", 8'h0A, {2'b00, ~pl, 5'b10010});
    rchk("portuse", 8'h08, 8'h00);
    rchk("unmapped", 8'h0B, 8'h00);
    $display("test reset done");
  endtask

  // charge enables refused outside config mode, reserved bits zero
  task automatic t_charge;
    host.wr(8'h06, 8'hFD);
    rchk("charge_off", 8'h06, 8'h02);
    @(posedge sys_clk) cfg_mode <= 1'b1;
    host.wr(8'h06, 8'hFF);
    rchk("charge_all", 8'h06, 8'h03);
    host.wr(8'h06, 8'h01);
    #1;
    check("chg_port1", {6'h0, chg}, 8'h01);
    host.wr(8'h08, 8'hFF);
    rchk("portuse_wr", 8'h08, 8'h00);
    $display("test charge done");
  endtask

  // removable bits follow inverted fuses until override is set
  task automatic t_remove;
    rchk("rmv_fuse", 8'h07, 8'h02);
    host.wr(8'h07, 8'h7D);
    rchk("rmv_locked", 8'h07, 8'h02);
    host.wr(8'h07, 8'h8F);
    rchk("rmv_rsvd", 8'h07, 8'h80);
    host.wr(8'h07, 8'h81);
    @(posedge sys_clk) fixed_attach <= 2'h2;
    rchk("rmv_own", 8'h07, 8'h81);
    check("rmv_port", {6'h0, rmv}, 8'h01);
    check("ovr_out", {7'h0, ovr}, 8'h01);
    $display("test remove done");
  endtask

  // reserved phy bits and second settings register
  task automatic t_misc;
    host.wr(8'h09, 8'hFF);
    rchk("phy", 8'h09, 8'h00);
    check("phy_out", phy, 8'h00);
    host.wr(8'h0A, 8'hFF);
    rchk("set2_wr", 8'h0A, 8'h7E);
    check("set2_out", set2, 8'h7E);
    host.wr(8'h0A, 8'h00);
    rchk("set2_fuse", 8'h0A, 8'h12);
    $display("test misc done");
  endtask

  initial
  begin
    t_reset(2'h2, 1'b0);
    t_charge();
    t_remove();
    t_misc();
    t_reset(2'h1, 1'b1);
    give_verdict();
  end

  initial
  begin
    #4000;
    fails++;
    give_verdict();
  end
endmodule
